// [psw_phy_model.sv]
// behavioural phy management responder for register reads
`timescale 1ns/10ps
module psw_phy_model (
    input  wire logic       core_clk,     // system clock
    input  wire logic       rst_n,        // async reset, active low
    input  wire logic       mdio_rd_req,  // read wanted
    input  wire logic [7:0] mdio_rd_addr, // register address
    output logic            mdio_rd_done, // one-cycle completion
    output logic [15:0]     mdio_rd_data  // address and its inverse
);
    int dly;
    // alternates prompt and slow answers; idle data toggles each cycle, but holds while a slow answer waits
    initial begin
        mdio_rd_done = 1'b0;
        mdio_rd_data = 16'h5A5A;
        dly = 0;
        forever begin
            @(posedge core_clk);
            if (rst_n === 1'b1 && mdio_rd_req === 1'b1) begin
                repeat (dly) @(posedge core_clk);
                mdio_rd_done <= 1'b1;
                mdio_rd_data <= {mdio_rd_addr, ~mdio_rd_addr};
                @(posedge core_clk);
                mdio_rd_done <= 1'b0;
                mdio_rd_data <= 16'hC3C3;
                dly = 3 - dly;
            end else begin
                mdio_rd_data <= ~mdio_rd_data;
            end
        end
    end
endmodule : psw_phy_model

// [psw_pkg.sv]
// package of constants and types for the phy select, wakeup and status block
package psw_pkg;
    // register indices; byte address is four times the index (printed offsets are not multiples of four)
    localparam logic [7:0]  IDX_PHY_CHOICE_STATUS  = 8'h21;
    localparam logic [7:0]  IDX_PHY_CHOICE_CONTROL = 8'h22;
    localparam logic [7:0]  IDX_MONITOR_MODE       = 8'h1D;
    localparam logic [7:0]  IDX_WAKE_CONFIG        = 8'h30;
    localparam logic [7:0]  IDX_IRQ_STATUS         = 8'h31;
    localparam logic [7:0]  IDX_IRQ_MASK           = 8'h32;
    localparam logic [7:0]  IDX_EEPROM_PHYREG      = 8'h33;
    localparam logic [7:0]  IDX_WAKE_STATE         = 8'h34;
    // field positions
    localparam int          POS_PHY_CHOICE      = 4;
    localparam int          POS_AUTO_PHY_CHOICE = 5;
    localparam int          POS_WAKE_ON_LINK    = 1;
    localparam int          POS_WAKE_ON_MAGIC   = 2;
    localparam int          POS_WAKE_ALLOW      = 0;
    localparam int          POS_REMOTE_WAKE_EN  = 1;
    localparam int          POS_PRIMARY_LINK    = 0;
    localparam int          POS_SECONDARY_LINK  = 1;
    localparam int          POS_LEN_PARITY_ERR  = 2;
    localparam int          POS_PHY_INT_LEVEL   = 3;
    // irq status bit positions
    localparam int          IRQ_WAKE     = 0;
    localparam int          IRQ_LINK_CHG = 1;
    localparam int          IRQ_REPORT   = 2;
    localparam int          IRQ_BITS     = 3;
    // reset values
    localparam logic        RST_PHY_CHOICE      = 1'b1;
    localparam logic        RST_AUTO_PHY_CHOICE = 1'b1;
    localparam logic        RST_WAKE_ON         = 1'b0;
    localparam logic [15:0] RST_EEPROM_PHYREG   = 16'h0000;
    // report layout
    localparam logic [7:0]  REPORT_HDR0 = 8'hA1;
    localparam logic [7:0]  REPORT_HDR1 = 8'h00;
    localparam logic [7:0]  REPORT_PAD  = 8'h00;
    localparam int          REPORT_BYTES = 8;
    // operating modes
    typedef enum logic [1:0] {
        PSW_MODE_RUN     = 2'b00,
        PSW_MODE_SUSPEND = 2'b01,
        PSW_MODE_WAKE    = 2'b10
    } psw_mode_e;
    // report build states
    typedef enum logic [1:0] {
        PSW_RPT_IDLE  = 2'b00,
        PSW_RPT_RD_HI = 2'b01,
        PSW_RPT_RD_LO = 2'b10,
        PSW_RPT_DONE  = 2'b11
    } psw_rpt_e;
endpackage : psw_pkg

// [psw_props.sv]
// checker of wake, report and phy read timing at the psw_top ports
`timescale 1ns/10ps
module psw_props (
    input wire logic        core_clk,        // system clock
    input wire logic        rst_n,           // async reset, active low
    input wire logic        host_resume,     // host resume seen
    input wire logic        wake_allow_flag, // eeprom permission
    input wire logic        mdio_rd_done,    // phy read complete
    input wire logic        mdio_rd_req,     // phy read request
    input wire logic [7:0]  mdio_rd_addr,    // phy register address
    input wire logic        suspended,       // device in suspend
    input wire logic        remote_wake,     // local wake pulse
    input wire logic        report_valid,    // report ready pulse
    input wire logic [63:0] report_data      // 8-byte report
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // wake steps: request seen while asleep, then the pulse of a local wake
    sequence s_resume; suspended && host_resume; endsequence
    sequence s_local; remote_wake; endsequence
    property p_host_wake; s_resume |-> ##[1:3] !suspended; endproperty
    property p_local_gate; s_local |-> $past(wake_allow_flag) && $past(suspended); endproperty
    property p_wake_pulse; s_local |=> !remote_wake; endproperty
    property p_wake_exit; s_local |-> ##[0:2] !suspended; endproperty
    property p_hdr; report_valid |-> report_data[63:48] == 16'hA100
        && report_data[39:32] == 8'h00; endproperty
    property p_rsvd; report_valid |-> report_data[47:44] == 4'h0; endproperty
    // the report must follow the second phy read by the fixed two cycles
    property p_after_rd; report_valid |-> $past(mdio_rd_done, 2); endproperty
    property p_rd_hold; mdio_rd_req && !mdio_rd_done |=> mdio_rd_req
        && $stable(mdio_rd_addr); endproperty
    a_host_wake: assert property (p_host_wake) else $error("resume did not wake");
    a_local_gate: assert property (p_local_gate) else $error("wake not allowed");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
    a_wake_exit: assert property (p_wake_exit) else $error("still suspended");
    a_hdr: assert property (p_hdr) else $error("report header wrong");
    a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
    a_after_rd: assert property (p_after_rd) else $error("report timing wrong");
    a_rd_hold: assert property (p_rd_hold) else $error("phy read dropped");
endmodule : psw_props

bind psw_top psw_props i_psw_props (.core_clk, .rst_n, .host_resume, .wake_allow_flag,
    .mdio_rd_done, .mdio_rd_req, .mdio_rd_addr, .suspended, .remote_wake, .report_valid,
    .report_data);

// [psw_report.sv]
// builder of the 8-byte interrupt endpoint report
`timescale 1ns/10ps
module psw_report (
    input  wire logic        core_clk,       // system clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic        report_req,     // host polls interrupt endpoint
    input  wire logic [15:0] phyreg_addrs,   // eeprom word hi/lo addresses
    input  wire logic [7:0]  status_byte,    // live status byte 3
    output logic             mdio_rd_req,    // phy register read request
    output logic [7:0]       mdio_rd_addr,   // phy register address
    input  wire logic        mdio_rd_done,   // read complete pulse
    input  wire logic [15:0] mdio_rd_data,   // read data
    output logic             report_valid,   // report ready pulse
    output logic [63:0]      report_data     // byte 1 in bits 63:56
);
    typedef struct packed {
        psw_pkg::psw_rpt_e state;
        logic [7:0]        status;
        logic [15:0]       snap_hi;
        logic [15:0]       snap_lo;
        logic              valid;
        logic [63:0]       data;
    } psw_rpt_s;

    psw_rpt_s st_reg;
    psw_rpt_s st_next;

    // each poll samples status and both registers fresh
    always_comb begin
        st_next       = st_reg;
        st_next.valid = 1'b0;
        case (st_reg.state)
            psw_pkg::PSW_RPT_IDLE: begin
                if (report_req) begin
                    st_next.status = status_byte;
                    st_next.state  = psw_pkg::PSW_RPT_RD_HI;
                end
            end
            psw_pkg::PSW_RPT_RD_HI: begin
                if (mdio_rd_done) begin
                    st_next.snap_hi = mdio_rd_data;
                    st_next.state   = psw_pkg::PSW_RPT_RD_LO;
                end
            end
            psw_pkg::PSW_RPT_RD_LO: begin
                if (mdio_rd_done) begin
                    st_next.snap_lo = mdio_rd_data;
                    st_next.state   = psw_pkg::PSW_RPT_DONE;
                end
            end
            default: begin
                // header pair, status, zero byte, two snapshots
                st_next.data  = {psw_pkg::REPORT_HDR0, psw_pkg::REPORT_HDR1,
                                 st_reg.status, psw_pkg::REPORT_PAD,
                                 st_reg.snap_hi, st_reg.snap_lo};
                st_next.valid = 1'b1;
                st_next.state = psw_pkg::PSW_RPT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{state: psw_pkg::PSW_RPT_IDLE, status: 8'h00, snap_hi: 16'h0000,
                        snap_lo: 16'h0000, valid: 1'b0, data: 64'h0000_0000_0000_0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // address hi byte first, then lo byte
    assign mdio_rd_req  = (st_reg.state == psw_pkg::PSW_RPT_RD_HI)
                        | (st_reg.state == psw_pkg::PSW_RPT_RD_LO);
    assign mdio_rd_addr = (st_reg.state == psw_pkg::PSW_RPT_RD_LO) ? phyreg_addrs[7:0]
                                                                   : phyreg_addrs[15:8];
    assign report_valid = st_reg.valid;
    assign report_data  = st_reg.data;
endmodule : psw_report

// [psw_top.sv]
// top of phy choice, remote wakeup and interrupt report block with ahb-lite registers
`timescale 1ns/10ps
module psw_top (
    input  wire logic        core_clk,          // system clock, 50 mhz
    input  wire logic        rst_n,             // async reset, active low
    input  wire logic        hsel,              // ahb slave select
    input  wire logic [31:0] haddr,             // ahb address
    input  wire logic [1:0]  htrans,            // ahb transfer type
    input  wire logic        hwrite,            // ahb write
    input  wire logic [2:0]  hsize,             // ahb size
    input  wire logic [31:0] hwdata,            // ahb write data
    input  wire logic        hready,            // ahb bus ready
    output logic [31:0]      hrdata,            // ahb read data
    output logic             hreadyout,         // ahb slave ready
    output logic             hresp,             // ahb response, always okay
    input  wire logic        primary_link_up,   // embedded phy link state
    input  wire logic        secondary_link_up, // external phy link state
    input  wire logic        out_length_parity_err, // bulk-out length parity
    input  wire logic        phy_int_level,     // phy interrupt pin level
    input  wire logic        wake_allow_flag,   // loaded from eeprom
    input  wire logic        suspend_req,       // usb core suspend
    input  wire logic        host_resume,       // host resume seen
    input  wire logic        magic_rx,          // magic packet pulse
    input  wire logic        ext_wake_pin_n,    // external wake pin
    input  wire logic        report_req,        // interrupt endpoint poll
    input  wire logic        mdio_rd_done,      // phy read complete
    input  wire logic [15:0] mdio_rd_data,      // phy read data
    output logic             mdio_rd_req,       // phy read request
    output logic [7:0]       mdio_rd_addr,      // phy register address
    output logic             use_embedded_phy,  // mac routed to embedded phy
    output logic             suspended,         // device in suspend
    output logic             remote_wake,       // device-initiated resume pulse
    output logic             report_valid,      // report ready pulse
    output logic [63:0]      report_data,       // 8-byte report
    output logic             irq                // level interrupt
);
    typedef struct packed {
        logic                          phy_choice;
        logic                          auto_phy_choice;
        logic                          wake_on_magic;
        logic                          wake_on_link;
        logic                          remote_wake_en;
        logic [15:0]                   eeprom_phyreg;
        logic [psw_pkg::IRQ_BITS-1:0]  irq_status;
        logic [psw_pkg::IRQ_BITS-1:0]  irq_mask;
        logic                          prev_link;
        logic                          dp_write;
        logic [7:0]                    dp_idx;
        logic [31:0]                   rdata;
    } psw_top_s;

    psw_top_s                     st_reg;
    psw_top_s                     st_next;
    logic                         ap_valid;
    logic [7:0]                   ap_idx;
    logic [7:0]                   status_byte;
    logic                         wake_event;
    logic [psw_pkg::IRQ_BITS-1:0] irq_events;
    logic [psw_pkg::IRQ_BITS-1:0] irq_w1c;
    logic [7:0]                   wbyte;

    // address phase taken when selected, nonseq or seq, and bus ready
    assign ap_valid = hsel & htrans[1] & hready;
    assign ap_idx   = haddr[9:2];
    assign wbyte    = hwdata[7:0];

    // live status byte: links, parity error, pin level
    always_comb begin
        status_byte                              = 8'h00;
        status_byte[psw_pkg::POS_PRIMARY_LINK]   = primary_link_up;
        status_byte[psw_pkg::POS_SECONDARY_LINK] = secondary_link_up;
        status_byte[psw_pkg::POS_LEN_PARITY_ERR] = out_length_parity_err;
        status_byte[psw_pkg::POS_PHY_INT_LEVEL]  = phy_int_level;
    end

    // phy selection: auto follows the embedded link, manual follows phy_choice
    always_comb begin
        if (st_reg.auto_phy_choice) begin
            use_embedded_phy = primary_link_up;
        end else begin
            use_embedded_phy = st_reg.phy_choice;
        end
    end

    // interrupt sources
    assign irq_events[psw_pkg::IRQ_WAKE]     = wake_event;
    assign irq_events[psw_pkg::IRQ_LINK_CHG] = primary_link_up ^ st_reg.prev_link;
    assign irq_events[psw_pkg::IRQ_REPORT]   = report_valid;
    assign irq_w1c = (st_reg.dp_write && st_reg.dp_idx == psw_pkg::IDX_IRQ_STATUS)
                   ? hwdata[psw_pkg::IRQ_BITS-1:0] : '0;

    // register file: data phase writes, read data registered one cycle later
    always_comb begin
        st_next           = st_reg;
        st_next.prev_link = primary_link_up;
        st_next.dp_write  = ap_valid & hwrite;
        st_next.dp_idx    = ap_valid ? ap_idx : st_reg.dp_idx;
        // set wins over a simultaneous write-one clear
        st_next.irq_status = (st_reg.irq_status & ~irq_w1c) | irq_events;
        if (st_reg.dp_write) begin
            if (st_reg.dp_idx == psw_pkg::IDX_PHY_CHOICE_CONTROL) begin
                st_next.phy_choice      = wbyte[psw_pkg::POS_PHY_CHOICE];
                st_next.auto_phy_choice = wbyte[psw_pkg::POS_AUTO_PHY_CHOICE];
            end else if (st_reg.dp_idx == psw_pkg::IDX_MONITOR_MODE) begin
                st_next.wake_on_magic = wbyte[psw_pkg::POS_WAKE_ON_MAGIC];
                st_next.wake_on_link  = wbyte[psw_pkg::POS_WAKE_ON_LINK];
            end else if (st_reg.dp_idx == psw_pkg::IDX_WAKE_CONFIG) begin
                st_next.remote_wake_en = wbyte[psw_pkg::POS_REMOTE_WAKE_EN];
            end else if (st_reg.dp_idx == psw_pkg::IDX_IRQ_MASK) begin
                st_next.irq_mask = hwdata[psw_pkg::IRQ_BITS-1:0];
            end else if (st_reg.dp_idx == psw_pkg::IDX_EEPROM_PHYREG) begin
                st_next.eeprom_phyreg = hwdata[15:0];
            end
        end
        // read mux; unmapped and write-only offsets read zero
        st_next.rdata = 32'h0000_0000;
        if (ap_valid && !hwrite) begin
            if (ap_idx == psw_pkg::IDX_PHY_CHOICE_STATUS) begin
                st_next.rdata[psw_pkg::POS_PHY_CHOICE]      = st_reg.phy_choice;
                st_next.rdata[psw_pkg::POS_AUTO_PHY_CHOICE] = st_reg.auto_phy_choice;
            end else if (ap_idx == psw_pkg::IDX_WAKE_CONFIG) begin
                st_next.rdata[psw_pkg::POS_WAKE_ALLOW]     = wake_allow_flag;
                st_next.rdata[psw_pkg::POS_REMOTE_WAKE_EN] = st_reg.remote_wake_en;
            end else if (ap_idx == psw_pkg::IDX_IRQ_STATUS) begin
                st_next.rdata[psw_pkg::IRQ_BITS-1:0] = st_reg.irq_status;
            end else if (ap_idx == psw_pkg::IDX_IRQ_MASK) begin
                st_next.rdata[psw_pkg::IRQ_BITS-1:0] = st_reg.irq_mask;
            end else if (ap_idx == psw_pkg::IDX_EEPROM_PHYREG) begin
                st_next.rdata[15:0] = st_reg.eeprom_phyreg;
            end else if (ap_idx == psw_pkg::IDX_WAKE_STATE) begin
                st_next.rdata[7:0] = status_byte;
                st_next.rdata[8]   = suspended;
                st_next.rdata[9]   = use_embedded_phy;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{phy_choice:      psw_pkg::RST_PHY_CHOICE,
                        auto_phy_choice: psw_pkg::RST_AUTO_PHY_CHOICE,
                        wake_on_magic:   psw_pkg::RST_WAKE_ON,
                        wake_on_link:    psw_pkg::RST_WAKE_ON,
                        remote_wake_en:  1'b0,
                        eeprom_phyreg:   psw_pkg::RST_EEPROM_PHYREG,
                        irq_status:      '0,
                        irq_mask:        '0,
                        prev_link:       1'b0,
                        dp_write:        1'b0,
                        dp_idx:          8'h00,
                        rdata:           32'h0000_0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // zero-wait slave: always ready, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata;
    assign irq       = |(st_reg.irq_status & st_reg.irq_mask);

    // wakeup decision
    psw_wake_ctrl u_wake (
        .core_clk          (core_clk),
        .rst_n             (rst_n),
        .suspend_req       (suspend_req),
        .host_resume       (host_resume),
        .wake_allow_flag   (wake_allow_flag),
        .remote_wake_en    (st_reg.remote_wake_en),
        .wake_on_magic     (st_reg.wake_on_magic),
        .wake_on_link      (st_reg.wake_on_link),
        .magic_rx          (magic_rx),
        .primary_link_up   (primary_link_up),
        .secondary_link_up (secondary_link_up),
        .ext_wake_pin_n    (ext_wake_pin_n),
        .suspended         (suspended),
        .remote_wake       (remote_wake),
        .wake_event        (wake_event)
    );

    // report assembly
    psw_report u_report (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .report_req   (report_req),
        .phyreg_addrs (st_reg.eeprom_phyreg),
        .status_byte  (status_byte),
        .mdio_rd_req  (mdio_rd_req),
        .mdio_rd_addr (mdio_rd_addr),
        .mdio_rd_done (mdio_rd_done),
        .mdio_rd_data (mdio_rd_data),
        .report_valid (report_valid),
        .report_data  (report_data)
    );
endmodule : psw_top

// [psw_wake_ctrl.sv]
// suspend and remote wakeup decision logic
`timescale 1ns/10ps
module psw_wake_ctrl (
    input  wire logic       core_clk,        // system clock
    input  wire logic       rst_n,           // async reset, active low
    input  wire logic       suspend_req,     // bus asks device to suspend
    input  wire logic       host_resume,     // host signals resume j to k
    input  wire logic       wake_allow_flag, // eeprom permission flag
    input  wire logic       remote_wake_en,  // set_feature remote wakeup
    input  wire logic       wake_on_magic,   // magic packet wake enable
    input  wire logic       wake_on_link,    // link-up wake enable
    input  wire logic       magic_rx,        // magic packet seen pulse
    input  wire logic       primary_link_up,   // embedded phy link
    input  wire logic       secondary_link_up, // external phy link
    input  wire logic       ext_wake_pin_n,  // external wake pin
    output logic            suspended,       // device is in suspend
    output logic            remote_wake,     // device-initiated wake pulse
    output logic            wake_event       // any wake pulse
);
    typedef struct packed {
        psw_pkg::psw_mode_e mode;
        logic               prev_pri;
        logic               prev_sec;
        logic               prev_pin;
        logic               rwake;
        logic               wevent;
    } psw_wake_s;

    psw_wake_s st_reg;
    psw_wake_s st_next;
    logic      local_ok;
    logic      link_rise;
    logic      pin_low_pulse;

    // local wake needs both the eeprom flag and the host feature
    assign local_ok      = wake_allow_flag & remote_wake_en;
    assign link_rise     = (primary_link_up & ~st_reg.prev_pri)
                         | (secondary_link_up & ~st_reg.prev_sec);
    assign pin_low_pulse = ~ext_wake_pin_n & st_reg.prev_pin;

    // mode machine; the pin always counts once local wake is allowed
    always_comb begin
        st_next          = st_reg;
        st_next.prev_pri = primary_link_up;
        st_next.prev_sec = secondary_link_up;
        st_next.prev_pin = ext_wake_pin_n;
        st_next.rwake    = 1'b0;
        st_next.wevent   = 1'b0;
        case (st_reg.mode)
            psw_pkg::PSW_MODE_RUN: begin
                if (suspend_req) begin
                    st_next.mode = psw_pkg::PSW_MODE_SUSPEND;
                end
            end
            psw_pkg::PSW_MODE_SUSPEND: begin
                if (host_resume) begin
                    st_next.mode   = psw_pkg::PSW_MODE_WAKE;
                    st_next.wevent = 1'b1;
                end else if (local_ok && ((wake_on_magic && magic_rx)
                             || (wake_on_link && link_rise) || pin_low_pulse)) begin
                    st_next.mode   = psw_pkg::PSW_MODE_WAKE;
                    st_next.rwake  = 1'b1;
                    st_next.wevent = 1'b1;
                end
            end
            default: begin
                // back to run; other config regs were never touched
                st_next.mode = psw_pkg::PSW_MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{mode: psw_pkg::PSW_MODE_RUN, prev_pri: 1'b0, prev_sec: 1'b0,
                        prev_pin: 1'b1, rwake: 1'b0, wevent: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign suspended   = (st_reg.mode == psw_pkg::PSW_MODE_SUSPEND);
    assign remote_wake = st_reg.rwake;
    assign wake_event  = st_reg.wevent;
endmodule : psw_wake_ctrl

// [tb_top.sv]
// self-checking bench: registers, phy choice, wake sources, irq and reports
`timescale 1ns/10ps
module tb_top;
    logic        core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic        primary_link_up, secondary_link_up, out_length_parity_err, phy_int_level;
    logic        wake_allow_flag, suspend_req, host_resume, magic_rx, ext_wake_pin_n;
    logic        report_req, mdio_rd_done, mdio_rd_req, use_embedded_phy, suspended;
    logic        remote_wake, report_valid, hit;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  mdio_rd_addr;
    logic [15:0] mdio_rd_data;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [63:0] report_data;
    int          n_mismatch, total_checks;
    psw_top i_psw_top (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .primary_link_up, .secondary_link_up,
        .out_length_parity_err, .phy_int_level, .wake_allow_flag, .suspend_req, .host_resume,
        .magic_rx, .ext_wake_pin_n, .report_req, .mdio_rd_done, .mdio_rd_data, .mdio_rd_req,
        .mdio_rd_addr, .use_embedded_phy, .suspended, .remote_wake, .report_valid,
        .report_data, .irq);
    psw_phy_model i_psw_phy_model (.core_clk, .rst_n, .mdio_rd_req, .mdio_rd_addr,
        .mdio_rd_done, .mdio_rd_data);
    assign hready = hreadyout; // single slave drives the bus ready
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask : tick
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one whole-word transfer: address phase, then data phase, both held until ready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {22'h0, idx, 2'b00}; hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdc
    // suspend, raise one wake source (0 magic, 1 link, 2 pin, 3 host), check outcome
    task automatic wake_try(input int src, input logic exp);
        suspend_req <= 1'b1; tick(1); suspend_req <= 1'b0; tick(2);
        chk(suspended, 1'b1);
        case (src)
            0: magic_rx <= 1'b1;
            1: secondary_link_up <= 1'b1;
            2: ext_wake_pin_n <= 1'b0;
            default: host_resume <= 1'b1;
        endcase
        tick(1); magic_rx <= 1'b0; host_resume <= 1'b0; hit = 1'b0;
        repeat (4) begin tick(1); if (remote_wake === 1'b1) hit = 1'b1; end
        ext_wake_pin_n <= 1'b1; secondary_link_up <= 1'b0; tick(2);
        chk(hit, exp && src != 3);
        chk(suspended, !exp);
    endtask : wake_try
    // report with given status inputs; phy data is address and its inverse
    task automatic rpt(input logic [3:0] st);
        {phy_int_level, out_length_parity_err, secondary_link_up, primary_link_up} <= st;
        report_req <= 1'b1; tick(1); report_req <= 1'b0;
        repeat (50) begin tick(1); if (report_valid === 1'b1) break; end
        chk(report_data, {16'hA100, 4'h0, st, 8'h00, 16'h01FE, 16'h02FD});
    endtask : rpt
    task complete_run;
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        rst_n <= 1'b0; hsel <= 1'b0; haddr <= 32'h0; htrans <= 2'b00; hwrite <= 1'b0;
        hsize <= 3'b010; hwdata <= 32'h0; {primary_link_up, secondary_link_up} <= 2'b00;
        {out_length_parity_err, phy_int_level, wake_allow_flag} <= 3'b000;
        {suspend_req, host_resume, magic_rx, report_req} <= 4'h0; ext_wake_pin_n <= 1'b1;
        tick(5); rst_n <= 1'b1; tick(1);
        rdc(psw_pkg::IDX_PHY_CHOICE_STATUS, 32'h30);
        primary_link_up <= 1'b1; tick(2); chk(use_embedded_phy, 1'b1);
        primary_link_up <= 1'b0; tick(2); chk(use_embedded_phy, 1'b0);
        bus(1'b1, psw_pkg::IDX_PHY_CHOICE_CONTROL, 32'h10); tick(1);
        chk(use_embedded_phy, 1'b1);
        primary_link_up <= 1'b1; bus(1'b1, psw_pkg::IDX_PHY_CHOICE_CONTROL, 32'h0); tick(1);
        chk(use_embedded_phy, 1'b0);
        rdc(psw_pkg::IDX_PHY_CHOICE_STATUS, 32'h0);
        rdc(8'h3F, 32'h0);
        wake_try(2, 1'b0);
        wake_try(3, 1'b1);
        wake_allow_flag <= 1'b1; bus(1'b1, psw_pkg::IDX_WAKE_CONFIG, 32'h2);
        wake_try(0, 1'b0);
        wake_try(2, 1'b1);
        bus(1'b1, psw_pkg::IDX_MONITOR_MODE, 32'h6);
        wake_try(0, 1'b1);
        wake_try(1, 1'b1);
        bus(1'b1, psw_pkg::IDX_IRQ_MASK, 32'h1); tick(1); chk(irq, 1'b1);
        bus(1'b1, psw_pkg::IDX_IRQ_STATUS, 32'h1); tick(1); chk(irq, 1'b0);
        bus(1'b1, psw_pkg::IDX_EEPROM_PHYREG, 32'h0102);
        rpt(4'h5);
        rpt(4'hA);
        bus(1'b1, psw_pkg::IDX_IRQ_MASK, 32'h4); tick(1); chk(irq, 1'b1);
        chk(hresp, 1'b0);
        complete_run;
    end
    // watchdog against a hang
    initial begin
        tick(20000);
        n_mismatch++;
        complete_run;
    end
endmodule : tb_top
